// *** fs_measure_conceal.sv ***
// fs measurement, parity concealment and stream flags with AHB-Lite registers
//
// Overview of operation
// - A PCM sample with parity error is replaced from earlier data.
// - Non-PCM (status bit 1 set) samples pass unchanged despite parity error.
// - A sudden jump of measured fs is treated as loss of lock.
// - Measurement counts cycles of the 24.576 MHz reference input.
// - A reference held at ground gives no measurement.
// - Reference frequency error shifts the result, not the fixed ranges.
// - The fs code comes from measurement, never from channel status.
// - The code drives two pins, high bit and low bit.
// - 32k range gives HH, 44.1k range LL, 48k range LH.
// - Unlocked, or locked out of every range, gives HL.
// - With no reference since reset the code stays LL.
// - A stopped reference freezes the last code.
// - A returning reference resumes measurement.
// - A computed code holds until the next window completes.
// - Any fs in the supported range is tracked continuously.
// - Status and user bits change 17 bit clocks after a frame edge.
// - On lock error the clock falls back to free run, no hold.
// - Block start flag is high for 8 frame periods after preamble B.
// - Error output is unlock OR parity error.
`timescale 1ns/1ps
module fs_measure_conceal
  import fs_conceal_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic      [31:0]                 hrdata,
  // pins from outside the clock domain
  input  wire logic                        ref_clock_in,
  input  wire logic                        frame_clock,
  input  wire logic                        bit_clock,
  // decoder side, same clock
  input  wire logic                        pll_locked,
  input  wire fs_conceal_pkg::sample_in_t  sample_in,
  // outputs
  output fs_conceal_pkg::sample_out_t      sample_out,
  output logic                             fs_code_hi,
  output logic                             fs_code_lo,
  output logic                             error_out,
  output logic                             free_run,
  output logic                             block_start_flag,
  output logic                             cs_out,
  output logic                             u_out
);
  import fs_conceal_pkg::*;

  state_t      st_r;
  state_t      st_nxt;
  logic [2:0]  pins_s;
  logic        ref_s;
  logic        frm_s;
  logic        bck_s;
  logic        ref_rise;
  logic        frm_rise;
  logic        frm_edge;
  logic        bck_rise;
  logic        lock_eff;
  logic        done;
  logic        jump;
  logic [15:0] diff;
  logic        addr_ph;
  logic        b_start;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  sync2 #(
    .W (3)
  ) u_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .d       ({ref_clock_in, frame_clock, bit_clock}),
    .q       (pins_s)
  );

  assign ref_s = pins_s[2];
  assign frm_s = pins_s[1];
  assign bck_s = pins_s[0];

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    st_nxt   = st_r;
    ref_rise = ref_s & ~st_r.ref_q;
    frm_rise = frm_s & ~st_r.frm_q;
    frm_edge = frm_s ^ st_r.frm_q;
    bck_rise = bck_s & ~st_r.bck_q;
    lock_eff = pll_locked & ~st_r.jump_unlock;
    done     = 1'b0;
    jump     = 1'b0;
    diff     = '0;
    addr_ph  = hsel & hready & htrans[1];
    b_start  = sample_in.valid & sample_in.preamble_b & ~sample_in.right;

    st_nxt.ref_q = ref_s;
    st_nxt.frm_q = frm_s;
    st_nxt.bck_q = bck_s;

    // bus: read data is prepared in the address phase, so no wait states
    st_nxt.wr_pend = addr_ph & hwrite;
    if (addr_ph)
    begin
      st_nxt.wr_addr = haddr[7:0];
      st_nxt.hrdata  = '0;
      if (!hwrite)
      begin
        case (haddr[7:0])
          CTRL_OFS:  st_nxt.hrdata[1:0] = st_r.ctrl;
          STAT_OFS:
          begin
            st_nxt.hrdata[1:0]          = st_r.fs_code;
            st_nxt.hrdata[ST_LOCK_BIT]  = lock_eff;
            st_nxt.hrdata[ST_REF_BIT]   = st_r.ref_active;
            st_nxt.hrdata[ST_NPCM_BIT]  = st_r.nonpcm;
            st_nxt.hrdata[ST_ERR_BIT]   = st_r.error;
            st_nxt.hrdata[ST_JUMP_BIT]  = st_r.jump_unlock;
          end
          COUNT_OFS: st_nxt.hrdata[15:0] = st_r.last_cnt;
          default:   st_nxt.hrdata = '0;  // unmapped reads as zero
        endcase
      end
    end
    if (st_r.wr_pend && st_r.wr_addr == CTRL_OFS)
      st_nxt.ctrl = hwdata[1:0];

    // reference activity watch; a grounded input never arms anything
    if (ref_rise)
    begin
      st_nxt.idle_cnt   = '0;
      st_nxt.ref_active = 1'b1;
      st_nxt.ref_seen   = 1'b1;
    end
    else if (st_r.idle_cnt != REF_IDLE_CYC)
      st_nxt.idle_cnt = st_r.idle_cnt + 4'h1;
    else
      st_nxt.ref_active = 1'b0;

    // measurement window: reference cycles over FS_FRAMES frames
    case (st_r.ms)
      MS_IDLE:
      begin
        if (st_r.ref_active && st_r.ctrl[CTRL_MEAS_BIT])
          st_nxt.ms = MS_ARM;
      end
      MS_ARM:
      begin
        if (frm_rise)
        begin
          st_nxt.ms      = MS_RUN;
          st_nxt.ref_cnt = '0;
          st_nxt.frm_cnt = '0;
        end
      end
      MS_RUN:
      begin
        if (ref_rise && st_r.ref_cnt != CNT_MAX)
          st_nxt.ref_cnt = st_r.ref_cnt + 16'h1;
        // a window never closes on the cycle the reference is seen stopped
        if (frm_rise && st_r.ref_active)
        begin
          st_nxt.frm_cnt = st_r.frm_cnt + 4'h1;
          if (st_r.frm_cnt == 4'(FS_FRAMES - 1))
          begin
            done           = 1'b1;
            st_nxt.ref_cnt = '0;
            st_nxt.frm_cnt = '0;
          end
        end
      end
      default: st_nxt.ms = MS_IDLE;
    endcase
    // a stopped reference abandons the window and freezes the code
    if (!st_r.ref_active || !st_r.ctrl[CTRL_MEAS_BIT])
      st_nxt.ms = MS_IDLE;

    // result; nothing from channel status ever reaches the code
    if (done)
    begin
      diff = (st_r.ref_cnt > st_r.last_cnt) ? st_r.ref_cnt - st_r.last_cnt
                                            : st_r.last_cnt - st_r.ref_cnt;
      jump = st_r.meas_valid && (diff > (st_r.last_cnt >> JUMP_SHIFT));
      st_nxt.jump_unlock = jump;
      st_nxt.last_cnt    = st_r.ref_cnt;
      st_nxt.meas_valid  = 1'b1;
      if (!pll_locked || jump)
        st_nxt.fs_code = FS_BAD;
      else
        st_nxt.fs_code = fs_classify(st_r.ref_cnt);
    end

    // concealment and non-PCM pass-through
    st_nxt.aout.valid = 1'b0;
    if (sample_in.valid)
    begin
      st_nxt.aout.valid = 1'b1;
      st_nxt.aout.right = sample_in.right;
      st_nxt.aout.data  = sample_in.data;
      st_nxt.par_flag   = sample_in.parity_err;
      if (sample_in.parity_err && !st_r.nonpcm &&
          st_r.ctrl[CTRL_CONCEAL_BIT])
        st_nxt.aout.data = sample_in.right ? st_r.last_r
                                           : st_r.last_l;
      if (!sample_in.parity_err && sample_in.right)
        st_nxt.last_r = sample_in.data;
      if (!sample_in.parity_err && !sample_in.right)
        st_nxt.last_l = sample_in.data;
      // left-channel status bit 1 marks non-PCM data
      if (!sample_in.right)
      begin
        st_nxt.cs_idx = b_start ? 8'h00 : st_r.cs_idx + 8'h01;
        if (!b_start && st_r.cs_idx == NONPCM_BIT - 8'h01)
          st_nxt.nonpcm = sample_in.cs;
      end
      st_nxt.cs_pend = sample_in.cs;
      st_nxt.u_pend  = sample_in.u;
    end

    // error and clock-source fallback follow the effective lock
    st_nxt.free_run = ~(pll_locked & ~st_nxt.jump_unlock);
    st_nxt.error    = st_nxt.free_run | st_nxt.par_flag;

    // block start flag for eight frame periods
    if (b_start)
    begin
      st_nxt.bf     = 1'b1;
      st_nxt.bf_cnt = '0;
    end
    else if (st_r.bf && frm_rise)
    begin
      if (st_r.bf_cnt == BSTART_FRAMES)
        st_nxt.bf = 1'b0;
      else
        st_nxt.bf_cnt = st_r.bf_cnt + 3'h1;
    end

    // status and user bits move 17 bit clocks after each frame edge
    if (frm_edge)
    begin
      st_nxt.bck_run = 1'b1;
      st_nxt.bck_cnt = '0;
    end
    else if (st_r.bck_run && bck_rise)
    begin
      st_nxt.bck_cnt = st_r.bck_cnt + 5'h1;
      if (st_r.bck_cnt == CSU_DELAY_BCK - 5'h1)
      begin
        st_nxt.cs_out  = st_r.cs_pend;
        st_nxt.u_out   = st_r.u_pend;
        st_nxt.bck_run = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register; the code resets to LL and moves only on a window

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r          <= '0;
      st_r.rdy      <= 1'b1;
      st_r.ctrl     <= CTRL_RST;
      st_r.ms       <= MS_IDLE;
      st_r.fs_code  <= FS_RST;
      st_r.free_run <= 1'b1;
      st_r.error    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign hreadyout        = st_r.rdy;
  assign hresp            = st_r.rsp;
  assign hrdata           = st_r.hrdata;
  assign sample_out       = st_r.aout;
  assign fs_code_hi       = st_r.fs_code[1];
  assign fs_code_lo       = st_r.fs_code[0];
  assign error_out        = st_r.error;
  assign free_run         = st_r.free_run;
  assign block_start_flag = st_r.bf;
  assign cs_out           = st_r.cs_out;
  assign u_out            = st_r.u_out;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence pcm_bad_left_s;
    sample_in.valid && sample_in.parity_err && !sample_in.right &&
    !st_r.nonpcm && st_r.ctrl[CTRL_CONCEAL_BIT];
  endsequence

  sequence preamble_s;
    sample_in.valid && sample_in.preamble_b && !sample_in.right;
  endsequence

  conceal_left_a: assert property (
    pcm_bad_left_s |=> sample_out.data == $past(st_r.last_l))
    else $error("bad PCM sample not replaced by last good left sample");

  nonpcm_pass_a: assert property (
    sample_in.valid && sample_in.parity_err && st_r.nonpcm
    |=> sample_out.data == $past(sample_in.data))
    else $error("non-PCM sample was altered");

  jump_unlock_a: assert property (
    done && jump |=> st_r.jump_unlock ##0 st_r.fs_code == FS_BAD)
    else $error("fs jump not treated as unlock");

  no_ref_ll_a: assert property (
    !st_r.ref_seen |-> st_r.fs_code == FS_44)
    else $error("fs code left LL without any reference");

  ref_freeze_a: assert property (
    !st_r.ref_active |=> $stable(st_r.fs_code))
    else $error("fs code moved with the reference stopped");

  unlock_code_a: assert property (
    done && !pll_locked |=> fs_code_hi && !fs_code_lo)
    else $error("unlocked window did not give HL");

  csu_delay_a: assert property (
    $changed(cs_out) |-> $past(st_r.bck_cnt) == CSU_DELAY_BCK - 5'h1)
    else $error("status bit moved off the 17th bit clock");

  block_flag_a: assert property (
    preamble_s |=> block_start_flag ##1 block_start_flag)
    else $error("block start flag not raised on preamble");

  error_or_a: assert property (
    !pll_locked || (sample_in.valid && sample_in.parity_err)
    |=> error_out && ($past(pll_locked) || free_run))
    else $error("error output missed unlock or parity error");

endmodule : fs_measure_conceal

// *** fs_conceal_pkg.sv ***
// shared constants, carriers and state type of the fs measure / conceal block
package fs_conceal_pkg;

  // clock and measurement reference
  localparam int SYS_HZ         = 50_000_000;
  localparam int REF_HZ         = 24_576_000;  // measurement reference
  localparam int FS_FRAMES      = 16;          // frames per measurement
  localparam int REF_IDLE_NS    = 200;         // no ref edge this long: stopped
  localparam int REF_IDLE_CYC_I =
    (REF_IDLE_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] REF_IDLE_CYC = 4'(REF_IDLE_CYC_I);

  // count windows, reference cycles per FS_FRAMES frames
  localparam logic [15:0] CNT_32_MIN = 16'(REF_HZ * FS_FRAMES / 32800);
  localparam logic [15:0] CNT_32_MAX = 16'(REF_HZ * FS_FRAMES / 31200);
  localparam logic [15:0] CNT_44_MIN = 16'(REF_HZ * FS_FRAMES / 45200);
  localparam logic [15:0] CNT_44_MAX = 16'(REF_HZ * FS_FRAMES / 43000);
  localparam logic [15:0] CNT_48_MIN = 16'(REF_HZ * FS_FRAMES / 49200);
  localparam logic [15:0] CNT_48_MAX = 16'(REF_HZ * FS_FRAMES / 46800);
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam int          JUMP_SHIFT = 4;      // jump above count/16 = unlock

  // fs codes {hi, lo}
  localparam logic [1:0] FS_32  = 2'b11;
  localparam logic [1:0] FS_44  = 2'b00;
  localparam logic [1:0] FS_48  = 2'b01;
  localparam logic [1:0] FS_BAD = 2'b10;
  localparam logic [1:0] FS_RST = FS_44;

  // stream timing
  localparam logic [2:0] BSTART_FRAMES = 3'd7;   // last of 8 frame periods
  localparam logic [4:0] CSU_DELAY_BCK = 5'd17;
  localparam logic [7:0] NONPCM_BIT    = 8'h01;

  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam int         CTRL_CONCEAL_BIT = 0;
  localparam int         CTRL_MEAS_BIT    = 1;
  localparam logic [1:0] CTRL_RST         = 2'b11;
  localparam int         ST_LOCK_BIT  = 2;
  localparam int         ST_REF_BIT   = 3;
  localparam int         ST_NPCM_BIT  = 4;
  localparam int         ST_ERR_BIT   = 5;
  localparam int         ST_JUMP_BIT  = 6;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ARM  = 2'b01,
    MS_RUN  = 2'b11
  } meas_state_t;

  typedef struct packed {
    logic        valid;
    logic        right;
    logic        parity_err;
    logic        cs;
    logic        u;
    logic        preamble_b;
    logic [23:0] data;
  } sample_in_t;

  typedef struct packed {
    logic        valid;
    logic        right;
    logic [23:0] data;
  } sample_out_t;

  typedef struct packed {
    logic        rdy;
    logic        rsp;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic [1:0]  ctrl;
    logic        ref_q;
    logic        frm_q;
    logic        bck_q;
    logic [3:0]  idle_cnt;
    logic        ref_active;
    logic        ref_seen;
    meas_state_t ms;
    logic [15:0] ref_cnt;
    logic [3:0]  frm_cnt;
    logic [15:0] last_cnt;
    logic        meas_valid;
    logic        jump_unlock;
    logic [1:0]  fs_code;
    logic [23:0] last_l;
    logic [23:0] last_r;
    sample_out_t aout;
    logic [7:0]  cs_idx;
    logic        nonpcm;
    logic        par_flag;
    logic        error;
    logic        free_run;
    logic        bf;
    logic [2:0]  bf_cnt;
    logic        cs_pend;
    logic        u_pend;
    logic        bck_run;
    logic [4:0]  bck_cnt;
    logic        cs_out;
    logic        u_out;
  } state_t;

  // map a window count to the fs code; ranges are fixed counts from the nominal REF_HZ
  function automatic logic [1:0] fs_classify(input logic [15:0] cnt);
    if (cnt >= CNT_32_MIN && cnt <= CNT_32_MAX)
      return FS_32;
    else if (cnt >= CNT_44_MIN && cnt <= CNT_44_MAX)
      return FS_44;
    else if (cnt >= CNT_48_MIN && cnt <= CNT_48_MAX)
      return FS_48;
    else
      return FS_BAD;
  endfunction : fs_classify

endpackage : fs_conceal_pkg

// *** sync2.sv ***
// two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // the first stage feeds only the second one
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2

// *** fs_src_model.sv ***
// far-side model: reference oscillator, frame clock and bit clock
`timescale 1ns/1ps
module fs_src_model #(
  parameter real FR_HALF = 10416.667
) (
  input  wire logic ref_en,
  output logic      ref_clock_in,
  output logic      frame_clock,
  output logic      bit_clock
);
  ////////////////////////////////////////////////////////////
  // reference oscillator; an unused pin is tied to ground
  initial ref_clock_in = 1'b0;
  always #20.345 ref_clock_in = ref_en ? !ref_clock_in : 1'b0;

  // audio stream clocks run freely; the stream never pauses
  initial frame_clock = 1'b0;
  always #(FR_HALF) frame_clock = !frame_clock;
  initial bit_clock = 1'b0;
  always #80 bit_clock = !bit_clock;
endmodule : fs_src_model

// *** tb_top.sv ***
// self-checking bench for fs measurement and parity concealment
`timescale 1ns/1ps
module tb_top;
  import fs_conceal_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        ref_en = 1'b0;
  logic        pll_locked = 1'b1;
  sample_in_t  sample_in = '0;
  sample_out_t sample_out;
  logic        hreadyout, hresp, fs_code_hi, fs_code_lo;
  logic        error_out, free_run, block_start_flag, cs_out, u_out;
  logic        ref_clock_in, frame_clock, bit_clock;
  logic [31:0] hrdata, rd;
  logic [23:0] last_l = '0;
  logic [23:0] last_r = '0;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          i;

  ////////////////////////////////////////////////////////////
  always #10 sys_clk = !sys_clk;

  fs_measure_conceal fs_measure_conceal_i (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ref_clock_in(ref_clock_in),
    .frame_clock(frame_clock), .bit_clock(bit_clock),
    .pll_locked(pll_locked), .sample_in(sample_in),
    .sample_out(sample_out), .fs_code_hi(fs_code_hi),
    .fs_code_lo(fs_code_lo), .error_out(error_out), .free_run(free_run),
    .block_start_flag(block_start_flag), .cs_out(cs_out), .u_out(u_out)
  );

  fs_src_model fs_src_model_i (
    .ref_en(ref_en), .ref_clock_in(ref_clock_in),
    .frame_clock(frame_clock), .bit_clock(bit_clock)
  );

  ////////////////////////////////////////////////////////////
  // compare helpers, one per result kind
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_word

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // a hang ends the run as a failure
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // single AHB-Lite word transfer; waits on hready, never a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask : ahb

  // expected output word: bad PCM repeats the channel's last good word
  function automatic logic [23:0] exp_data(input logic r, pe, np, en,
                                           input logic [23:0] dd);
    if (pe && !np && en)
      return r ? last_r : last_l;
    return dd;
  endfunction : exp_data

  // one sample with random data, compared one cycle after it is driven
  task automatic samp(input logic r, pe, c, pb, np, en);
    logic [23:0] dd;
    logic [23:0] ex;
    dd = 24'($urandom());
    ex = exp_data(r, pe, np, en, dd);
    @(posedge sys_clk);
    sample_in <= '{1'b1, r, pe, c, c, pb, dd};
    @(posedge sys_clk);
    sample_in.valid <= 1'b0;
    #1;
    chk_bit(sample_out.valid, 1'b1);
    chk_bit(sample_out.right, r);
    chk_word({8'h00, sample_out.data}, {8'h00, ex});
    chk_bit(error_out, pe);
    if (!pe && !r)
      last_l = dd;
    if (!pe && r)
      last_r = dd;
  endtask : samp

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(32'h7300));
    repeat (10) @(posedge sys_clk);
    chk_bit(fs_code_hi, 1'b0);
    chk_bit(fs_code_lo, 1'b0);
    chk_bit(free_run, 1'b1);
    nrst <= 1'b1;
    ahb(1'b0, 32'(CTRL_OFS), '0, rd);
    chk_word(rd, 32'h3);
    ahb(1'b0, 32'h0C, '0, rd);
    chk_word(rd, 32'h0);
    chk_bit(hresp, 1'b0);
    chk_bit(hreadyout, 1'b1);
    // concealment of PCM words, one idle cycle apart, then with concealment off
    samp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    samp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    samp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    samp(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    ahb(1'b1, 32'(CTRL_OFS), 32'h2, rd);
    samp(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    ahb(1'b1, 32'(CTRL_OFS), 32'h3, rd);
    samp(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    // lock loss: error raised and clock falls back to free run
    pll_locked <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_bit(error_out, 1'b1);
    chk_bit(free_run, 1'b1);
    pll_locked <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_bit(free_run, 1'b0);
    // block start, then a non-PCM word with bad parity passes as is
    @(posedge frame_clock);
    repeat (8) @(posedge sys_clk);
    samp(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    chk_bit(block_start_flag, 1'b1);
    samp(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    samp(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    samp(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (7) @(posedge frame_clock);
    repeat (8) @(posedge sys_clk);
    chk_bit(block_start_flag, 1'b1);
    @(posedge frame_clock);
    repeat (8) @(posedge sys_clk);
    chk_bit(block_start_flag, 1'b0);
    // status and user bits move 17 bit clocks after a frame edge
    samp(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    @(frame_clock);
    repeat (20) @(posedge bit_clock);
    repeat (4) @(posedge sys_clk);
    chk_bit(cs_out, 1'b0);
    samp(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    @(frame_clock);
    repeat (14) @(posedge bit_clock);
    chk_bit(cs_out, 1'b0);
    repeat (6) @(posedge bit_clock);
    repeat (4) @(posedge sys_clk);
    chk_bit(cs_out, 1'b1);
    chk_bit(u_out, 1'b1);
    // no reference so far: code must still read LL
    repeat (6) @(posedge frame_clock);
    chk_bit(fs_code_hi, 1'b0);
    chk_bit(fs_code_lo, 1'b0);
    // reference arrives: 48 kHz stream must settle to LH
    ref_en <= 1'b1;
    i = 0;
    while ({fs_code_hi, fs_code_lo} !== FS_48 && i < 40)
    begin
      @(posedge frame_clock);
      i++;
    end
    chk_word({30'h0, fs_code_hi, fs_code_lo}, 32'(FS_48));
    ahb(1'b0, 32'(COUNT_OFS), '0, rd);
    i = REF_HZ / 48000 * FS_FRAMES;
    chk_bit(int'(rd[15:0]) >= i - 4 && int'(rd[15:0]) <= i + 4, 1'b1);
    ahb(1'b0, 32'(STAT_OFS), '0, rd);
    chk_word({30'h0, rd[1:0]}, 32'(FS_48));
    // reference stops and lock drops: last code stays
    ref_en <= 1'b0;
    pll_locked <= 1'b0;
    repeat (18) @(posedge frame_clock);
    chk_word({30'h0, fs_code_hi, fs_code_lo}, 32'(FS_48));
    chk_bit(free_run, 1'b1);
    end_of_test();
  end
endmodule : tb_top
